// [include/wdnmi_consts.vh]
`ifndef WDNMI_CONSTS_VH
`define WDNMI_CONSTS_VH
// Register byte addresses on APB; the control word sits at four times its register index.
`define WDNMI_ADDR_W          18
`define WDNMI_CONTROL_IDX     16'hff07
`define WDNMI_CONTROL_ADDR    18'h3fc1c
`define WDNMI_OSC_CFG_ADDR    18'h00000
`define WDNMI_STATUS_ADDR     18'h00004
`define WDNMI_IRQ_EN_ADDR     18'h00008
`define WDNMI_IRQ_CLR_ADDR    18'h0000c
`define WDNMI_COUNT_ADDR      18'h00010
// Field positions in the control register.
`define WDNMI_RESTART_BIT     0
`define WDNMI_ENABLE_BIT      1
`define WDNMI_ENABLE_RST      1'b1
// Counter and tick figures.
`define WDNMI_CNT_W           10
`define WDNMI_TICK_HZ         256
`define WDNMI_OSC_HZ          32768
`define WDNMI_DIV_W           16
`endif

// [hdl/wdnmi_sync2.v]
`timescale 1ns/100ps
`default_nettype none
module wdnmi_sync2
(
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire d_in,
  output wire q_out
);
  reg meta_r;
  reg sync_r;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end
  assign q_out = sync_r;
endmodule // wdnmi_sync2
`default_nettype wire

// [hdl/wdnmi_tick_div.v]
`timescale 1ns/100ps
`default_nettype none
`include "wdnmi_consts.vh"
// Divides synchronised low-speed oscillator edges down to one tick pulse.
module wdnmi_tick_div
#(
  parameter DIV_W = `WDNMI_DIV_W
)
(
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             osc_edge_in,
  input  wire [DIV_W-1:0] ratio_in,
  output reg              tick_out
);
  reg [DIV_W-1:0] cnt_r;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r    <= {DIV_W{1'b0}};
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (osc_edge_in)
      begin
        if (cnt_r + 1'b1 >= ratio_in)
        begin
          cnt_r    <= {DIV_W{1'b0}};
          tick_out <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule // wdnmi_tick_div
`default_nettype wire

// [hdl/wdnmi_top.v]
// Overview of operation
// - Counter advances on a 256 Hz tick divided from the low-speed oscillator.
// - Counting starts after reset with no software action; software may stop it.
// - Without restart for about four seconds (1023 to 1024 ticks), raise the NMI.
// - Ten-bit binary counter; NMI on overflow of the 0.25 Hz last stage.
// - Counting continues in halt; the NMI then releases the halt.
// - Enable bit is read-write; one counts, zero stops and suppresses NMI.
// - Enable bit is one after reset.
// - Writing one to restart clears the counter; counting resumes at once if the same write sets the enable bit to one.
// - Restart bit is write-only and reads zero.
`timescale 1ns/100ps
`default_nettype none
`include "wdnmi_consts.vh"
module wdnmi_top
#(
  parameter CNT_W = `WDNMI_CNT_W,
  parameter DIV_W = `WDNMI_DIV_W
)
(
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        osc_low_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [17:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  output reg         nmi_pulse_out,
  output reg         irq_out
);
  localparam integer     RATIO_INT = `WDNMI_OSC_HZ / `WDNMI_TICK_HZ;
  localparam [DIV_W-1:0] RATIO_RST = RATIO_INT[DIV_W-1:0];
  // One-hot register selects; an all-zero select marks an unmapped address.
  localparam [5:0]       SEL_CONTROL = 6'h01;
  localparam [5:0]       SEL_OSC_CFG = 6'h02;
  localparam [5:0]       SEL_STATUS  = 6'h04;
  localparam [5:0]       SEL_IRQ_EN  = 6'h08;
  localparam [5:0]       SEL_IRQ_CLR = 6'h10;
  localparam [5:0]       SEL_COUNT   = 6'h20;

  reg              enable_r;
  reg  [CNT_W-1:0] count_r;
  reg  [DIV_W-1:0] ratio_r;
  reg              status_r;
  reg              irq_en_r;
  reg              osc_d_r;
  wire             osc_s;
  wire             tick;
  wire             osc_edge;
  wire             wr_acc;
  wire             rd_acc;
  wire             restart;
  wire             overflow;
  wire             setup_cyc;
  wire             clear_wr;
  wire             count_en;
  wire [5:0]       reg_hit;

  // The oscillator pin is asynchronous, so it is synchronised before edge detection.
  wdnmi_sync2 u_sync
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (osc_low_in),
    .q_out    (osc_s)
  );

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      osc_d_r <= 1'b0;
    else
      osc_d_r <= osc_s;
  end
  assign osc_edge = osc_s & ~osc_d_r;

  wdnmi_tick_div #(.DIV_W(DIV_W)) u_div
  (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .osc_edge_in (osc_edge),
    .ratio_in    (ratio_r),
    .tick_out    (tick)
  );

  function addr_is;
    input [17:0] a;
    input [17:0] ref_a;
    begin
      addr_is = (a == ref_a);
    end
  endfunction

  // The address is held through both bus phases, so one decode serves setup and access.
  function [5:0] reg_sel;
    input [17:0] a;
    begin
      case (a)
        `WDNMI_CONTROL_ADDR:
        begin
          reg_sel = SEL_CONTROL;
        end
        `WDNMI_OSC_CFG_ADDR:
        begin
          reg_sel = SEL_OSC_CFG;
        end
        `WDNMI_STATUS_ADDR:
        begin
          reg_sel = SEL_STATUS;
        end
        `WDNMI_IRQ_EN_ADDR:
        begin
          reg_sel = SEL_IRQ_EN;
        end
        `WDNMI_IRQ_CLR_ADDR:
        begin
          reg_sel = SEL_IRQ_CLR;
        end
        `WDNMI_COUNT_ADDR:
        begin
          reg_sel = SEL_COUNT;
        end
        default:
        begin
          reg_sel = 6'h00;
        end
      endcase
    end
  endfunction

  assign reg_hit   = reg_sel(paddr_in);
  assign setup_cyc = psel_in & ~penable_in;

  // Writes take effect in the access cycle; the slave always answers with no wait.
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_acc = psel_in & ~penable_in & ~pwrite_in;
  assign restart = wr_acc & addr_is(paddr_in, `WDNMI_CONTROL_ADDR) & pwdata_in[`WDNMI_RESTART_BIT];
  // Overflow of the last stage happens once every 1024 ticks, about four seconds.
  assign overflow = tick & enable_r & ~restart & (&count_r);
  assign count_en = tick & enable_r;
  assign clear_wr = wr_acc & (reg_hit == SEL_IRQ_CLR) & pwdata_in[0];

  // Writes land at the access edge only, so a setup cycle alone never changes state.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      enable_r <= `WDNMI_ENABLE_RST;
    else if (wr_acc & (reg_hit == SEL_CONTROL))
      enable_r <= pwdata_in[`WDNMI_ENABLE_BIT];
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ratio_r <= RATIO_RST;
    else if (wr_acc & (reg_hit == SEL_OSC_CFG))
      ratio_r <= pwdata_in[DIV_W-1:0];
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_en_r <= 1'b0;
    else if (wr_acc & (reg_hit == SEL_IRQ_EN))
      irq_en_r <= pwdata_in[0];
  end

  // The counter has no halt input, so it keeps running while the CPU halts.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_r <= {CNT_W{1'b0}};
    end
    else if (restart)
    begin
      count_r <= {CNT_W{1'b0}};
    end
    else if (count_en)
    begin
      count_r <= count_r + 1'b1;
    end
  end

  // The NMI is a single registered pulse per overflow.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      nmi_pulse_out <= 1'b0;
    else
      nmi_pulse_out <= overflow;
  end

  // A new overflow wins over a clear in the same cycle, so no event is lost.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      status_r <= 1'b0;
    else if (overflow)
      status_r <= 1'b1;
    else if (clear_wr)
      status_r <= 1'b0;
  end

  // The overflow term lets the level rise in the same cycle as the pulse.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= (status_r | overflow) & irq_en_r;
  end

  // The slave never inserts wait states: ready follows every setup cycle by one clock.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= setup_cyc;
      pslverr_out <= setup_cyc & ~(|reg_hit);
    end
  end

  // Read data is captured in the setup cycle so that it stands with ready.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out <= 32'h00000000;
    end
    else if (rd_acc)
    begin
      case (reg_hit)
        SEL_CONTROL:
        begin
          prdata_out <= {{30{1'b0}}, enable_r, 1'b0};
        end
        SEL_OSC_CFG:
        begin
          prdata_out <= {{(32-DIV_W){1'b0}}, ratio_r};
        end
        SEL_STATUS:
        begin
          prdata_out <= {{31{1'b0}}, status_r};
        end
        SEL_IRQ_EN:
        begin
          prdata_out <= {{31{1'b0}}, irq_en_r};
        end
        SEL_IRQ_CLR:
        begin
          prdata_out <= 32'h00000000;
        end
        SEL_COUNT:
        begin
          prdata_out <= {{(32-CNT_W){1'b0}}, count_r};
        end
        default:
        begin
          prdata_out <= 32'h00000000;
        end
      endcase
    end
  end
endmodule // wdnmi_top
`default_nettype wire

// [sim/wdnmi_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module wdnmi_cpu_model
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        nmi_in,
  input  wire logic        sp_pair_in,
  output logic      [15:0] pc_out,
  output int               taken_out
);
  // The interrupt flag is never looked at, because the watchdog request cannot be masked.
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      pc_out <= 16'h0000;
      taken_out <= 0;
    end
    else if (nmi_in && sp_pair_in)
    begin
      pc_out <= 16'h0100;
      taken_out <= taken_out + 1;
    end
endmodule // wdnmi_cpu_model
`default_nettype wire

// [sim/wdnmi_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module wdnmi_chk
(
  input wire logic        clk_in, rst_n_in, osc_low_in, psel_in, penable_in, pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic        pready_out, pslverr_out, nmi_pulse_out, irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire ctl = paddr_in == 18'h3fc1c;
  wire map = ctl | paddr_in == 18'h00000 | paddr_in == 18'h00004 | paddr_in == 18'h00008
             | paddr_in == 18'h0000c | paddr_in == 18'h00010;
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_quiet; !nmi_pulse_out [*8]; endsequence
  chk_ready_next: assert property (s_setup |=> pready_out) else $error("no ready after setup");
  chk_ready_single: assert property (pready_out |=> !pready_out) else $error("ready too long");
  chk_err_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  chk_unmapped_err: assert property (pready_out && !map |-> pslverr_out) else $error("no error");
  chk_mapped_ok: assert property (pready_out && map |-> !pslverr_out) else $error("false error");
  chk_restart_zero: assert property (pready_out && ctl && !pwrite_in |-> prdata_out[0] == 1'b0)
    else $error("restart bit read back");
  chk_nmi_single: assert property (nmi_pulse_out |=> !nmi_pulse_out) else $error("long pulse");
  chk_quiet_after: assert property (pready_out && ctl && pwrite_in && (pwdata_in[0] || !pwdata_in[1])
    |=> ##1 s_quiet) else $error("request after restart or stop");
endmodule // wdnmi_chk
`default_nettype wire

// [sim/wdnmi_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module wdnmi_tb_top;
  logic clk_in, rst_n_in, osc_low_in, psel_in, penable_in, pwrite_in, sp_pair, er;
  logic pready_out, pslverr_out, nmi_pulse_out, irq_out;
  logic [17:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [15:0] pc;
  int miscompares, num_checks, n, taken;
  typedef struct {logic [17:0] a; logic w; logic [31:0] d, q; logic e;} wdnmi_row_t;
  wdnmi_row_t rows [9] = '{'{18'h3fc1c, 0, 0, 2, 0}, '{18'h00000, 0, 0, 128, 0}, '{18'h00008, 0, 0, 0, 0},
    '{18'h0000c, 0, 0, 0, 0}, '{18'h00004, 0, 0, 0, 0}, '{18'h007fc, 0, 0, 0, 1}, '{18'h007fc, 1, 5, 0, 1},
    '{18'h00000, 1, 1, 0, 0}, '{18'h00000, 0, 0, 1, 0}};
  wdnmi_top u_wdnmi_top(.clk_in(clk_in), .rst_n_in(rst_n_in), .osc_low_in(osc_low_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .nmi_pulse_out(nmi_pulse_out), .irq_out(irq_out));
  wdnmi_cpu_model u_wdnmi_cpu_model(.clk_in(clk_in), .rst_n_in(rst_n_in), .nmi_in(nmi_pulse_out),
    .sp_pair_in(sp_pair), .pc_out(pc), .taken_out(taken));
  initial
  begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  // A divide ratio of one makes each oscillator rise a tick, so an overflow takes 2048 cycles.
  always @(posedge clk_in) osc_low_in <= ~osc_low_in;
  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic [17:0] a, input logic w, input logic [31:0] d);
    int k;
    psel_in <= 1;
    penable_in <= 0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    k = 0;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && k < 16)
    begin
      k++;
      @(posedge clk_in);
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    if (k >= 16)
    begin
      miscompares++;
      results;
    end
    @(posedge clk_in);
  endtask
  task wait_nmi;
    n = 0;
    @(posedge clk_in);
    while (nmi_pulse_out !== 1'b1 && n < 3000)
    begin
      n++;
      @(posedge clk_in);
    end
    if (n >= 3000)
    begin
      miscompares++;
      results;
    end
  endtask
  initial
  begin
    {rst_n_in, osc_low_in, psel_in, penable_in, pwrite_in, sp_pair, paddr_in, pwdata_in} = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1;
    @(posedge clk_in);
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk(er === rows[i].e && (rows[i].w || rd === rows[i].q));
    end
    wait_nmi;
    chk(n < 2100);
    repeat (2) @(posedge clk_in);
    chk(taken === 0 && irq_out === 1'b0);
    apb(18'h00004, 0, 0);
    chk(rd === 32'h1);
    apb(18'h00008, 1, 1);
    repeat (2) @(posedge clk_in);
    chk(irq_out === 1'b1);
    apb(18'h0000c, 1, 1);
    repeat (2) @(posedge clk_in);
    chk(irq_out === 1'b0);
    sp_pair <= 1;
    apb(18'h3fc1c, 1, 3);
    apb(18'h3fc1c, 0, 0);
    chk(rd === 32'h2);
    wait_nmi;
    chk(n >= 2036 && n <= 2060);
    apb(18'h3fc1c, 1, 0);
    chk(taken === 1 && pc === 16'h0100);
    n = 0;
    repeat (2200)
    begin
      @(posedge clk_in);
      if (nmi_pulse_out === 1'b1) n++;
    end
    chk(n == 0);
    results;
  end
endmodule // wdnmi_tb_top
bind wdnmi_top wdnmi_chk u_wdnmi_chk(.clk_in(clk_in), .rst_n_in(rst_n_in), .osc_low_in(osc_low_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .nmi_pulse_out(nmi_pulse_out), .irq_out(irq_out));
`default_nettype wire
